// file: rtl/adgdr_pkg.sv
// Purpose: shared types and constants for adaptive gate delay regulation
// Assumes: one 20 MHz clock, gate current given as a 6-bit code
// Notes: durations and delays are counted in clock cycles
package adgdr_pkg;
    localparam int DW = 8;
    localparam int CW = 6;
    localparam int MW = 4;
    localparam logic [DW-1:0] DLY_MAX = 8'hFF;
    localparam logic [DW-1:0] DLY_ZERO = 8'h00;
    localparam logic [CW-1:0] CODE_MIN = 6'h00;
    localparam logic [CW-1:0] CODE_MAX = 6'h3F;
    localparam logic [CW:0] STEP_ONE = 7'h01;
    localparam logic [CW:0] STEP_TWO = 7'h02;
    localparam logic [MW-1:0] CNT_TOP = 4'hF;
    localparam logic [MW-1:0] CNT_ZERO = 4'h0;
    localparam logic [1:0] SIGN_CHG_NEED = 2'h3;
    localparam int REG_COUNT_DEF = 8;

    typedef enum logic [1:0] {
        SEL_NOPRE = 2'h0,
        SEL_FIXED = 2'h1,
        SEL_ADAPT = 2'h2,
        SEL_ADAPT_ALT = 2'h3
    } adgdr_sel_t;

    // gray along off, pre-charge, charge, on, pre-discharge, discharge, off
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_PCHG = 3'h1,
        ST_CHG = 3'h3,
        ST_ON = 3'h2,
        ST_PDCHG = 3'h6,
        ST_DCHG = 3'h4
    } adgdr_state_t;

    typedef enum logic [1:0] {
        SGN_NONE = 2'h0,
        SGN_POS = 2'h1,
        SGN_NEG = 2'h2
    } adgdr_sgn_t;

    typedef struct packed {
        logic charging;
        logic discharging;
        logic [CW-1:0] code;
    } adgdr_gate_t;

    typedef struct packed {
        adgdr_state_t st;
        logic [DW-1:0] dly;
        logic [DW-1:0] ph;
        logic [CW-1:0] pchg;
        logic [CW-1:0] pdchg;
        logic [DW-1:0] meas_on;
        logic [DW-1:0] meas_off;
        logic on_seen;
        logic done;
        logic pwm_d;
        logic en_d;
        adgdr_gate_t pg;
    } adgdr_st_t;

    typedef struct packed {
        logic [MW-1:0] cnt_on;
        logic [MW-1:0] cnt_off;
        adgdr_sgn_t sg_on;
        adgdr_sgn_t sg_off;
        logic [1:0] chg_on;
        logic [1:0] chg_off;
        logic flag;
    } adgdr_mon_t;
endpackage : adgdr_pkg

// file: rtl/adgdr_regmon.sv
// Purpose: match counters and sign-change tracker for one half-bridge
// Assumes: upd is a one-cycle pulse per completed PWM cycle
// Notes: clear holds everything at zero while not regulating
module adgdr_regmon #(
    parameter int REG_COUNT = adgdr_pkg::REG_COUNT_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic upd,
    input wire logic on_gt,
    input wire logic on_lt,
    input wire logic off_gt,
    input wire logic off_lt,
    output logic regulated
);
    import adgdr_pkg::*;

    localparam logic [MW-1:0] REG_THR = MW'(REG_COUNT);

    if (REG_COUNT < 1 || REG_COUNT > 15) begin : g_chk
        $error("REG_COUNT must lie in 1..15");
    end

    adgdr_mon_t m_r;
    adgdr_mon_t m_nxt;

    function automatic logic [MW-1:0] step_cnt(logic [MW-1:0] c, logic eq);
        if (eq) begin
            step_cnt = (c == CNT_TOP) ? c : c + 4'h1;
        end else begin
            step_cnt = (c == CNT_ZERO) ? c : c - 4'h1;
        end
    endfunction : step_cnt

    function automatic logic [1:0] step_chg(adgdr_sgn_t prev, adgdr_sgn_t cur,
                                            logic [1:0] c);
        if (cur == SGN_NONE) begin
            step_chg = c;
        end else if (prev != SGN_NONE && prev != cur) begin
            step_chg = (c == SIGN_CHG_NEED) ? c : c + 2'h1;
        end else begin
            step_chg = 2'h0;
        end
    endfunction : step_chg

    always_comb begin
        adgdr_sgn_t s_on;
        adgdr_sgn_t s_off;
        s_on = on_gt ? SGN_POS : (on_lt ? SGN_NEG : SGN_NONE);
        s_off = off_gt ? SGN_POS : (off_lt ? SGN_NEG : SGN_NONE);
        m_nxt = m_r;
        if (clear) begin
            m_nxt = '0;
        end else if (upd) begin
            m_nxt.cnt_on = step_cnt(m_r.cnt_on, !(on_gt || on_lt));
            m_nxt.cnt_off = step_cnt(m_r.cnt_off, !(off_gt || off_lt));
            m_nxt.chg_on = step_chg(m_r.sg_on, s_on, m_r.chg_on);
            m_nxt.chg_off = step_chg(m_r.sg_off, s_off, m_r.chg_off);
            if (s_on != SGN_NONE) begin
                m_nxt.sg_on = s_on;
            end
            if (s_off != SGN_NONE) begin
                m_nxt.sg_off = s_off;
            end
        end
        m_nxt.flag = !clear && ((m_nxt.cnt_on >= REG_THR && m_nxt.cnt_off >= REG_THR)
            || (m_nxt.chg_on == SIGN_CHG_NEED && m_nxt.chg_off == SIGN_CHG_NEED));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            m_r <= '0;
        end else begin
            m_r <= m_nxt;
        end
    end

    assign regulated = m_r.flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CNT_UP: assert property (upd && !clear && !on_gt && !on_lt && m_r.cnt_on != CNT_TOP
        |=> m_r.cnt_on == $past(m_r.cnt_on) + 4'h1) else $error("on counter did not rise");
    AST_CNT_DN: assert property (upd && !clear && off_gt && m_r.cnt_off != CNT_ZERO
        |=> m_r.cnt_off == $past(m_r.cnt_off) - 4'h1) else $error("off counter did not fall");
    AST_CNT_SAT: assert property (m_r.cnt_on == CNT_ZERO && upd && on_lt
        |=> m_r.cnt_on == CNT_ZERO) else $error("on counter wrapped below zero");
    AST_REG_SET: assert property (m_r.cnt_on >= REG_THR && m_r.cnt_off >= REG_THR
        |-> regulated) else $error("counters at threshold but flag low");
    AST_HOLD: assert property (!upd && !clear |=> $stable(m_r.cnt_on))
        else $error("on counter moved without a completed cycle");
    COV_REG: cover property (m_r.cnt_on >= REG_THR && m_r.cnt_off >= REG_THR);
    COV_SIGN: cover property (m_r.chg_on == SIGN_CHG_NEED && m_r.chg_off == SIGN_CHG_NEED);
endmodule : adgdr_regmon

// file: rtl/adgdr_top.sv
// Purpose: PWM gate sequencing with adaptive pre-charge and delay regulation
// Assumes: comparator and PWM inputs synchronous to clk; times in clk cycles
// Notes: the complementary transistor is held in sink; free-wheeling not modelled
// How it works
// - low-side PWM swaps gates and thresholds
// - regulated flag only valid in adaptive modes
// - regulated when both counters reach eight
// - turn-on counter up on match, else down
// - turn-off counter up on match, else down
// - three consecutive error sign changes also regulate
// - no modulation: one current per pre-phase
// - modulation splits each pre-phase into two in adaptive modes
// - non-adaptive codes stop delay regulation
// - delays still measured in non-adaptive modes
// - code zero-zero omits pre-phases entirely
// - code zero-one pre-charges with initial code
// - code zero-one pre-discharges with initial code
// - six-bit code, sixty-four current steps
// - larger code always means larger current
// - enable loads min of initial and maximum
// - adaptation steps one or two codes
module adgdr_top #(
    parameter int REG_COUNT = adgdr_pkg::REG_COUNT_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pwm_in,
    input wire logic map_low_side,
    input wire logic half_bridge_pwm_enable,
    input wire adgdr_pkg::adgdr_sel_t adaptive_control_select,
    input wire logic time_modulation_enable,
    input wire logic adaptation_step_size,
    input wire logic [adgdr_pkg::CW-1:0] initial_precharge_code,
    input wire logic [adgdr_pkg::CW-1:0] initial_predischarge_current,
    input wire logic [adgdr_pkg::CW-1:0] max_charge_current,
    input wire logic [adgdr_pkg::CW-1:0] charge_current_code,
    input wire logic [adgdr_pkg::CW-1:0] discharge_current_code,
    input wire logic [adgdr_pkg::DW-1:0] precharge_duration,
    input wire logic [adgdr_pkg::DW-1:0] predischarge_duration,
    input wire logic [adgdr_pkg::DW-1:0] turn_on_delay,
    input wire logic [adgdr_pkg::DW-1:0] turn_off_delay,
    input wire logic switch_node_high_threshold,
    input wire logic switch_node_low_threshold,
    output adgdr_pkg::adgdr_gate_t high_gate,
    output adgdr_pkg::adgdr_gate_t low_gate,
    output logic [adgdr_pkg::DW-1:0] measured_delay_status_a,
    output logic [adgdr_pkg::DW-1:0] measured_delay_status_b,
    output logic delay_regulated_flag
);
    import adgdr_pkg::*;

    adgdr_st_t s_r;
    adgdr_st_t s_nxt;

    logic rise;
    logic fall;
    logic on_det;
    logic off_det;
    logic adaptive;
    logic nopre;
    logic [CW:0] step;
    logic [CW-1:0] pchg_init;
    logic [CW-1:0] pdchg_init;
    logic mon_clear;

    assign rise = pwm_in && !s_r.pwm_d;
    assign fall = !pwm_in && s_r.pwm_d;
    // low-side PWM: turn-on completes at the low threshold, turn-off at the high one
    assign on_det = map_low_side ? switch_node_low_threshold
                                 : switch_node_high_threshold;
    assign off_det = map_low_side ? switch_node_high_threshold
                                  : switch_node_low_threshold;
    assign adaptive = adaptive_control_select[1];
    assign nopre = adaptive_control_select == SEL_NOPRE;
    assign step = adaptation_step_size ? STEP_TWO : STEP_ONE;
    assign pchg_init = (initial_precharge_code < max_charge_current)
        ? initial_precharge_code : max_charge_current;
    assign pdchg_init = (initial_predischarge_current < max_charge_current)
        ? initial_predischarge_current : max_charge_current;

    // saturating move of a current code, kept within minimum and maximum code
    function automatic logic [CW-1:0] adapt(logic [CW-1:0] c, logic up, logic dn,
                                            logic [CW:0] st, logic [CW-1:0] top);
        logic [CW:0] sum;
        sum = {1'b0, c} + st;
        adapt = c;
        if (up) begin
            adapt = (sum > {1'b0, top}) ? top : sum[CW-1:0];
        end else if (dn) begin
            adapt = ({1'b0, c} < st) ? CODE_MIN : c - st[CW-1:0];
        end
        if (adapt > top) begin
            adapt = top;
        end
    endfunction : adapt

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.pwm_d = pwm_in;
        s_nxt.en_d = half_bridge_pwm_enable;
        if (s_r.dly != DLY_MAX) begin
            s_nxt.dly = s_r.dly + 8'h01;
        end
        if (s_r.ph != DLY_MAX) begin
            s_nxt.ph = s_r.ph + 8'h01;
        end
        case (s_r.st)
            ST_OFF, ST_PDCHG, ST_DCHG: begin
                if (rise) begin
                    // a rise before turn-off completed abandons that cycle
                    s_nxt.dly = DLY_ZERO;
                    s_nxt.ph = DLY_ZERO;
                    s_nxt.on_seen = 1'b0;
                    s_nxt.st = (nopre || precharge_duration == DLY_ZERO)
                        ? ST_CHG : ST_PCHG;
                end else if (s_r.st != ST_OFF && off_det) begin
                    s_nxt.meas_off = s_r.dly;
                    s_nxt.done = s_r.on_seen;
                    s_nxt.on_seen = 1'b0;
                    s_nxt.st = ST_OFF;
                end else if (s_r.st == ST_PDCHG && s_nxt.ph >= predischarge_duration) begin
                    s_nxt.st = ST_DCHG;
                end
            end
            ST_PCHG, ST_CHG, ST_ON: begin
                if (fall) begin
                    s_nxt.dly = DLY_ZERO;
                    s_nxt.ph = DLY_ZERO;
                    s_nxt.st = (nopre || predischarge_duration == DLY_ZERO)
                        ? ST_DCHG : ST_PDCHG;
                end else if (s_r.st != ST_ON && on_det) begin
                    s_nxt.meas_on = s_r.dly;
                    s_nxt.on_seen = 1'b1;
                    s_nxt.st = ST_ON;
                end else if (s_r.st == ST_PCHG && s_nxt.ph >= precharge_duration) begin
                    s_nxt.st = ST_CHG;
                end
            end
            default: begin
                s_nxt.st = ST_OFF;
            end
        endcase
        if (!half_bridge_pwm_enable) begin
            s_nxt.st = ST_OFF;
            s_nxt.on_seen = 1'b0;
            s_nxt.done = 1'b0;
        end
        if (half_bridge_pwm_enable && !s_r.en_d) begin
            s_nxt.pchg = pchg_init;
            s_nxt.pdchg = pdchg_init;
        end else if (s_r.done && adaptive) begin
            // slow turn-on or turn-off asks for more pre-phase current
            s_nxt.pchg = adapt(s_r.pchg, s_r.meas_on > turn_on_delay,
                s_r.meas_on < turn_on_delay, step, max_charge_current);
            s_nxt.pdchg = adapt(s_r.pdchg, s_r.meas_off > turn_off_delay,
                s_r.meas_off < turn_off_delay, step, max_charge_current);
        end
        // gate drive follows the next state so the outputs stay registered
        s_nxt.pg = '{charging: 1'b0, discharging: 1'b1, code: CODE_MAX};
        case (s_nxt.st)
            ST_PCHG: begin
                s_nxt.pg.charging = 1'b1;
                s_nxt.pg.discharging = 1'b0;
                if (!adaptive) begin
                    s_nxt.pg.code = initial_precharge_code;
                end else if (time_modulation_enable
                             && s_nxt.ph < {1'b0, precharge_duration[DW-1:1]}) begin
                    s_nxt.pg.code = pchg_init;
                end else begin
                    s_nxt.pg.code = s_nxt.pchg;
                end
            end
            ST_CHG: begin
                s_nxt.pg.charging = 1'b1;
                s_nxt.pg.discharging = 1'b0;
                s_nxt.pg.code = charge_current_code;
            end
            ST_ON: begin
                s_nxt.pg.charging = 1'b1;
                s_nxt.pg.discharging = 1'b0;
                s_nxt.pg.code = max_charge_current;
            end
            ST_PDCHG: begin
                if (!adaptive) begin
                    s_nxt.pg.code = initial_predischarge_current;
                end else if (time_modulation_enable
                             && s_nxt.ph < {1'b0, predischarge_duration[DW-1:1]}) begin
                    s_nxt.pg.code = pdchg_init;
                end else begin
                    s_nxt.pg.code = s_nxt.pdchg;
                end
            end
            ST_DCHG: begin
                s_nxt.pg.code = discharge_current_code;
            end
            default: begin
                s_nxt.pg.code = CODE_MAX;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{st: ST_OFF, pg: '{charging: 1'b0, discharging: 1'b1, code: CODE_MAX},
                     default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // the complementary transistor is held off with full sink current
    localparam adgdr_gate_t GATE_HOLD = '{charging: 1'b0, discharging: 1'b1, code: CODE_MAX};
    assign high_gate = map_low_side ? GATE_HOLD : s_r.pg;
    assign low_gate = map_low_side ? s_r.pg : GATE_HOLD;
    assign measured_delay_status_a = s_r.meas_on;
    assign measured_delay_status_b = s_r.meas_off;

    assign mon_clear = !adaptive || !half_bridge_pwm_enable;

    adgdr_regmon #(
        .REG_COUNT(REG_COUNT)
    ) u_regmon (
        .clk(clk),
        .nrst(nrst),
        .clear(mon_clear),
        .upd(s_r.done),
        .on_gt(s_r.meas_on > turn_on_delay),
        .on_lt(s_r.meas_on < turn_on_delay),
        .off_gt(s_r.meas_off > turn_off_delay),
        .off_lt(s_r.meas_off < turn_off_delay),
        .regulated(delay_regulated_flag)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_LS_SWAP: assert property (map_low_side && s_r.st == ST_ON
        |-> low_gate.charging && !high_gate.charging) else $error("low-side swap broken");
    AST_FLAG_NA: assert property (!adaptive |=> !delay_regulated_flag)
        else $error("regulated flag set outside adaptive modes");
    AST_NOPRE: assert property (s_r.st == ST_OFF && rise && nopre && half_bridge_pwm_enable
        |=> s_r.st == ST_CHG) else $error("pre-charge not omitted");
    AST_FIX_PCHG: assert property (s_r.st == ST_PCHG && !$past(adaptive) && !adaptive
        |-> s_r.pg.code == $past(initial_precharge_code))
        else $error("fixed pre-charge code wrong");
    AST_FIX_PDCHG: assert property (s_r.st == ST_PDCHG && !$past(adaptive) && !adaptive
        |-> s_r.pg.code == $past(initial_predischarge_current))
        else $error("fixed pre-discharge code wrong");
    AST_SINGLE: assert property (s_r.st == ST_PCHG && adaptive && !time_modulation_enable
        |-> s_r.pg.code == s_r.pchg) else $error("pre-charge current not single");
    AST_INIT: assert property (half_bridge_pwm_enable && !s_r.en_d
        |=> s_r.pchg == $past(pchg_init) && s_r.pdchg == $past(pdchg_init))
        else $error("adaptive current not initialised");
    AST_MEAS: assert property (s_r.st == ST_DCHG && off_det && !rise && half_bridge_pwm_enable
        |=> measured_delay_status_b == $past(s_r.dly)) else $error("turn-off not measured");
    AST_STEP: assert property (s_r.done && adaptive && !(half_bridge_pwm_enable && !s_r.en_d)
        && s_r.meas_on > turn_on_delay && max_charge_current > 6'h01
        && s_r.pchg < max_charge_current - 6'h01
        |=> s_r.pchg == $past(s_r.pchg) + ($past(adaptation_step_size) ? 6'h02 : 6'h01))
        else $error("adaptation step wrong");
    COV_CYCLE: cover property (s_r.done && adaptive);
    COV_LOWSIDE: cover property (map_low_side && s_r.done);
    COV_TM: cover property (time_modulation_enable && s_r.st == ST_PCHG && s_r.pg.code != s_r.pchg);
endmodule : adgdr_top

// file: testbench/adgdr_gate_model.sv
// Purpose: switch-node model driven by the PWM transistor gate
// Assumes: node flips after a set number of charge or discharge cycles
// Notes: comparators are levels; node position is sticky between phases
module adgdr_gate_model
(
    input wire logic clk,
    input wire logic nrst,
    input wire adgdr_pkg::adgdr_gate_t high_gate,
    input wire adgdr_pkg::adgdr_gate_t low_gate,
    input wire logic map_low_side,
    input wire logic [7:0] on_lat,
    input wire logic [7:0] off_lat,
    output logic switch_node_high_threshold,
    output logic switch_node_low_threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    import adgdr_pkg::*;
    adgdr_gate_t pg;
    logic [7:0] cc_r, dc_r;
    logic node_on_r;
    assign pg = map_low_side ? low_gate : high_gate;
    // low-side PWM pulls the node low, so the comparators swap roles
    assign switch_node_high_threshold = map_low_side ? !node_on_r : node_on_r;
    assign switch_node_low_threshold = !switch_node_high_threshold;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cc_r <= 8'h00;
            dc_r <= 8'h00;
            node_on_r <= 1'b0;
        end else if (pg.charging) begin
            dc_r <= 8'h00;
            cc_r <= (cc_r == 8'hFF) ? cc_r : cc_r + 8'h01;
            if (cc_r + 8'h01 >= on_lat) node_on_r <= 1'b1;
        end else if (pg.discharging) begin
            cc_r <= 8'h00;
            dc_r <= (dc_r == 8'hFF) ? dc_r : dc_r + 8'h01;
            if (dc_r + 8'h01 >= off_lat) node_on_r <= 1'b0;
        end
    end
endmodule : adgdr_gate_model

// file: testbench/adgdr_top_tb_top.sv
// Purpose: directed bench for gate sequencing and delay regulation
// Assumes: inputs change on the falling edge; one PWM cycle per task call
// Notes: waits are long enough for any phase with durations of 8 cycles
module adgdr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adgdr_pkg::*;
    logic clk, nrst, pwm_in, map_low_side, en, tme, step, sh, sl, flag;
    adgdr_sel_t sel;
    logic [5:0] ipc, ipd, imax, ichg, idchg;
    logic [7:0] tpc, tpd, ton, toff, lat_on, lat_off, ma, mb;
    adgdr_gate_t hg, lg;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int i;
    adgdr_top #(.REG_COUNT(8)) u_dut (.clk(clk), .nrst(nrst), .pwm_in(pwm_in),
        .map_low_side(map_low_side), .half_bridge_pwm_enable(en),
        .adaptive_control_select(sel), .time_modulation_enable(tme),
        .adaptation_step_size(step), .initial_precharge_code(ipc),
        .initial_predischarge_current(ipd), .max_charge_current(imax),
        .charge_current_code(ichg), .discharge_current_code(idchg),
        .precharge_duration(tpc), .predischarge_duration(tpd), .turn_on_delay(ton),
        .turn_off_delay(toff), .switch_node_high_threshold(sh),
        .switch_node_low_threshold(sl), .high_gate(hg), .low_gate(lg),
        .measured_delay_status_a(ma), .measured_delay_status_b(mb),
        .delay_regulated_flag(flag));
    adgdr_gate_model u_model (.clk(clk), .nrst(nrst), .high_gate(hg), .low_gate(lg),
        .map_low_side(map_low_side), .on_lat(lat_on), .off_lat(lat_off),
        .switch_node_high_threshold(sh), .switch_node_low_threshold(sl));
    function automatic adgdr_gate_t gt(input logic c, input logic [5:0] code);
        return '{charging: c, discharging: !c, code: code};
    endfunction : gt
    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic cmp_gate(input string what, input adgdr_gate_t exp, input adgdr_gate_t got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_gate
    task automatic cmp_dly(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_dly
    task automatic cmp_flag(input logic exp);
        comparisons++;
        if (flag !== exp) begin
            num_errors++;
            $display("ERROR regulated flag expected %b seen %b", exp, flag);
        end
    endtask : cmp_flag
    // one full PWM period; c1/c6 are gate codes 1 and 6 cycles after the rise
    task automatic run_cycle(input logic [7:0] on_l, input logic [7:0] off_l,
        input logic [5:0] c1, input logic [5:0] c6, input logic [5:0] d1);
        lat_on = on_l;
        lat_off = off_l;
        pwm_in = 1'b1;
        @(negedge clk);
        cmp_gate("pwm gate rise", gt(1'b1, c1), map_low_side ? lg : hg);
        cmp_gate("held gate", gt(1'b0, 6'h3F), map_low_side ? hg : lg);
        repeat (5) @(negedge clk);
        cmp_gate("pwm gate later", gt(1'b1, c6), map_low_side ? lg : hg);
        repeat (34) @(negedge clk);
        cmp_dly("turn-on delay", on_l, ma);
        pwm_in = 1'b0;
        @(negedge clk);
        cmp_gate("pwm gate fall", gt(1'b0, d1), map_low_side ? lg : hg);
        repeat (40) @(negedge clk);
        cmp_dly("turn-off delay", off_l, mb);
    endtask : run_cycle
    // enable is dropped while mode settings change, which clears the monitor
    task automatic restart();
        en = 1'b0;
        repeat (2) @(negedge clk);
        en = 1'b1;
        repeat (2) @(negedge clk);
    endtask : restart
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {nrst, pwm_in, map_low_side, en, tme, step} = 6'h00;
        sel = SEL_ADAPT;
        {ipc, ipd, imax, ichg, idchg} = {6'h10, 6'h08, 6'h20, 6'h2A, 6'h15};
        {tpc, tpd, ton, toff, lat_on, lat_off} = {8'h08, 8'h08, 8'h0A, 8'h0A, 8'h14, 8'h14};
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        cmp_gate("reset high gate", gt(1'b0, 6'h3F), hg);
        cmp_gate("reset low gate", gt(1'b0, 6'h3F), lg);
        cmp_dly("reset delay", 8'h00, ma);
        cmp_flag(1'b0);
        $display("test reset done");
        step = 1'b1;
        restart();
        run_cycle(8'h14, 8'h14, 6'h10, 6'h10, 6'h08);
        run_cycle(8'h14, 8'h14, 6'h12, 6'h12, 6'h0A);
        tme = 1'b1;
        run_cycle(8'h14, 8'h14, 6'h10, 6'h14, 6'h08);
        tme = 1'b0;
        $display("test adaptation done");
        step = 1'b0;
        restart();
        for (i = 0; i < 8; i++) begin
            run_cycle(8'h0A, 8'h0A, 6'h10, 6'h10, 6'h08);
            if (i == 6) cmp_flag(1'b0);
        end
        cmp_flag(1'b1);
        // one slow cycle pulls both counters back below the threshold
        run_cycle(8'h14, 8'h14, 6'h10, 6'h10, 6'h08);
        cmp_flag(1'b0);
        $display("test match counters done");
        {ipc, ipd} = {6'h30, 6'h28};
        sel = SEL_FIXED;
        @(negedge clk);
        run_cycle(8'h14, 8'h14, 6'h30, 6'h30, 6'h28);
        cmp_flag(1'b0);
        $display("test fixed mode done");
        {ipc, ipd} = {6'h10, 6'h08};
        sel = SEL_ADAPT_ALT;
        restart();
        for (i = 0; i < 4; i++) begin
            run_cycle(i[0] ? 8'h09 : 8'h0B, i[0] ? 8'h09 : 8'h0B,
                i[0] ? 6'h11 : 6'h10, i[0] ? 6'h11 : 6'h10, i[0] ? 6'h09 : 6'h08);
            if (i == 2) cmp_flag(1'b0);
        end
        cmp_flag(1'b1);
        $display("test sign changes done");
        sel = SEL_NOPRE;
        map_low_side = 1'b1;
        @(negedge clk);
        run_cycle(8'h0F, 8'h0C, 6'h2A, 6'h2A, 6'h15);
        cmp_flag(1'b0);
        {ichg, idchg} = {6'h3F, 6'h00};
        @(negedge clk);
        run_cycle(8'h0F, 8'h0C, 6'h3F, 6'h3F, 6'h00);
        $display("test low side done");
        summarize();
    end
endmodule : adgdr_top_tb_top
